/* core/instruction_trace_unit.sv */
`timescale 1ns/10ps
`default_nettype none
`include "trace_consts.svh"

module instruction_trace_unit
   import trace_pkg::*;
#(
   parameter int ADR_W = 8
)
(
   input wire logic mclk_i, // System clock
   input wire logic rst_n_i, // Synchronous reset
   input wire logic wb_cyc_i, // Bus cycle
   input wire logic wb_stb_i, // Bus strobe
   input wire logic wb_we_i, // Bus write
   input wire logic [ADR_W-1:0] wb_adr_i, // Byte address
   input wire logic [3:0] wb_sel_i, // Byte enables
   input wire logic [31:0] wb_dat_i, // Write data
   output logic [31:0] wb_dat_o, // Read data
   output logic wb_ack_o, // Bus acknowledge
   input wire logic core_valid_i, // Instruction left execute
   input wire logic core_cond_pass_i, // Condition passed
   input wire logic core_branch_i, // Taken branch
   input wire logic [31:0] core_pc_i, // Executed address
   input wire logic [31:0] core_target_i, // Branch target
   output logic buffer_full_stall_o, // Core must hold
   input wire logic external_trigger_input_i, // Trigger pin
   input wire logic trace_clk_i, // Link clock
   output logic trace_port_clock_o, // Outgoing trace clock
   output logic [2:0] pipeline_state_code_o, // State code
   output logic packet_group_marker_o, // First packet flag
   output logic [3:0] packet_nibble_bus_o // Packet nibble
);

   function automatic logic [31:0] merge_bytes(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0] sel
   );
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   logic [31:0] ctrl;
   logic [31:0] range_lo;
   logic [31:0] range_hi;
   logic [3:0] map_ctrl;
   logic [15:0] count;
   logic [31:0] merged;
   logic bus_req;
   logic bus_wr;
   logic ext_s1;
   logic ext_s2;
   logic in_range;
   logic map_hit;
   logic count_zero;
   logic trace_on;
   logic trace_active;
   logic busy;
   logic req_tog;
   logic ack_s1;
   logic ack_s2;
   logic ack_tog;
   pipe_code_t word_code;
   logic word_branch;
   logic [31:0] word_addr;
   pipe_code_t next_code;

   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr = bus_req && wb_we_i;
   assign merged = merge_bytes({16'h0, count}, wb_dat_i, wb_sel_i);

   // Classic single cycle: ack one cycle after the strobe, dropped next cycle
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         wb_ack_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= bus_req;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         ctrl <= `CTRL_RESET;
         range_lo <= `RANGE_LO_RESET;
         range_hi <= `RANGE_HI_RESET;
         map_ctrl <= `MAP_RESET;
      end
      else if (bus_wr)
      begin
         case (wb_adr_i)
            `OFS_CTRL: ctrl <= merge_bytes(ctrl, wb_dat_i, wb_sel_i);
            `OFS_RANGE_LO: range_lo <= merge_bytes(range_lo, wb_dat_i, wb_sel_i);
            `OFS_RANGE_HI: range_hi <= merge_bytes(range_hi, wb_dat_i, wb_sel_i);
            `OFS_MAP_CTRL: map_ctrl <= wb_sel_i[0] ? wb_dat_i[3:0] : map_ctrl;
            default:
            begin
            end
         endcase
      end
   end

   // Unmapped addresses read as zero; writes to them are dropped
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         wb_dat_o <= 32'h0;
      end
      else if (bus_req && !wb_we_i)
      begin
         case (wb_adr_i)
            `OFS_CTRL: wb_dat_o <= ctrl;
            `OFS_STATUS: wb_dat_o <= {27'h0, in_range, ext_s2, count_zero, busy, trace_active};
            `OFS_RANGE_LO: wb_dat_o <= range_lo;
            `OFS_RANGE_HI: wb_dat_o <= range_hi;
            `OFS_MAP_CTRL: wb_dat_o <= {28'h0, map_ctrl};
            `OFS_COUNTER: wb_dat_o <= {16'h0, count};
            `OFS_CONFIG: wb_dat_o <= `CONFIG_WORD;
            default: wb_dat_o <= 32'h0;
         endcase
      end
   end

   // Trigger pin crosses into the system clock domain
   always_ff @(posedge mclk_i)
   begin
      ext_s1 <= external_trigger_input_i;
      ext_s2 <= ext_s1;
   end

   // Single comparator pair forms an inclusive address range
   assign in_range = (core_pc_i >= range_lo) && (core_pc_i <= range_hi);
   // Four decoders, one per quarter of the address map
   assign map_hit = map_ctrl[core_pc_i[31:30]];
   assign count_zero = (count == 16'h0);

   // The one counter counts executed addresses inside the range
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         count <= `COUNT_RESET;
      end
      else if (bus_wr && wb_adr_i == `OFS_COUNTER)
      begin
         count <= merged[15:0];
      end
      else if (core_valid_i && in_range && !count_zero && !busy)
      begin
         count <= count - 16'h1;
      end
   end

   // No sequencer and no data comparators exist to select
   always_comb
   begin
      trace_on = 1'b0;
      if (ctrl[`CTRL_EN_BIT])
      begin
         case (ctrl[`CTRL_SEL_LSB +: `CTRL_SEL_W])
            SEL_ALWAYS: trace_on = 1'b1;
            SEL_RANGE: trace_on = in_range;
            SEL_MAP: trace_on = map_hit;
            SEL_COUNT: trace_on = count_zero;
            SEL_EXT: trace_on = ext_s2;
            default: trace_on = 1'b0;
         endcase
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         trace_active <= 1'b0;
      end
      else
      begin
         trace_active <= trace_on;
      end
   end

   // Addresses other than branch targets never leave the block
   assign next_code = !core_cond_pass_i ? `PS_NOEXEC : (core_branch_i ? `PS_BRANCH : `PS_EXEC);

   // One word at a time crosses by toggle handshake; the core stalls
   // while it is in flight, trading throughput for no buffer at all
   always_ff @(posedge mclk_i)
   begin
      if (!rst_n_i)
      begin
         busy <= 1'b0;
         req_tog <= 1'b0;
         word_code <= `PS_IDLE;
         word_branch <= 1'b0;
         word_addr <= 32'h0;
      end
      else if (!busy && core_valid_i && trace_on)
      begin
         busy <= 1'b1;
         req_tog <= !req_tog;
         word_code <= next_code;
         word_branch <= core_cond_pass_i && core_branch_i;
         word_addr <= core_target_i;
      end
      else if (busy && ack_s2 == req_tog)
      begin
         busy <= 1'b0;
      end
   end

   assign buffer_full_stall_o = busy;

   always_ff @(posedge mclk_i)
   begin
      ack_s1 <= ack_tog;
      ack_s2 <= ack_s1;
   end

   // Link domain, clocked by the externally derived trace clock
   logic lrst_s1;
   logic lrst_s2;
   logic en_s1;
   logic en_s2;
   logic half_s1;
   logic half_s2;
   logic req_s1;
   logic req_s2;
   logic phase;
   logic [3:0] nib_left;
   logic [27:0] shift;

   always_ff @(posedge trace_clk_i)
   begin
      lrst_s1 <= rst_n_i;
      lrst_s2 <= lrst_s1;
      en_s1 <= ctrl[`CTRL_EN_BIT];
      en_s2 <= en_s1;
      half_s1 <= ctrl[`CTRL_HALF_BIT];
      half_s2 <= half_s1;
      req_s1 <= req_tog;
      req_s2 <= req_s1;
   end

   // Slots last two link cycles; data moves on phase high, the clock
   // rising edge, or at half rate each edge, comes one link cycle later, mid-slot, for hold margin
   always_ff @(posedge trace_clk_i)
   begin
      if (!lrst_s2 || !en_s2)
      begin
         phase <= 1'b0;
         trace_port_clock_o <= 1'b0;
      end
      else
      begin
         phase <= !phase;
         // Held low until the first slot, so the analyzer never clocks in idle
         if (!half_s2)
         begin
            trace_port_clock_o <= !phase && (pipeline_state_code_o != `PS_IDLE);
         end
         else if (!phase && pipeline_state_code_o != `PS_IDLE)
         begin
            trace_port_clock_o <= !trace_port_clock_o;
         end
      end
   end

   always_ff @(posedge trace_clk_i)
   begin
      if (!lrst_s2)
      begin
         ack_tog <= 1'b0;
         nib_left <= 4'h0;
         shift <= 28'h0;
         pipeline_state_code_o <= `PS_IDLE;
         packet_group_marker_o <= 1'b0;
         packet_nibble_bus_o <= 4'h0;
      end
      else if (!en_s2)
      begin
         ack_tog <= req_s2; // Drop a word caught by disable
         nib_left <= 4'h0;
         pipeline_state_code_o <= `PS_IDLE;
         packet_group_marker_o <= 1'b0;
         packet_nibble_bus_o <= 4'h0;
      end
      else if (phase)
      begin
         if (nib_left != 4'h0)
         begin
            nib_left <= nib_left - 4'h1;
            shift <= {4'h0, shift[27:4]};
            packet_nibble_bus_o <= shift[3:0];
            packet_group_marker_o <= (nib_left == `FIRST_PKT_HIGH);
            pipeline_state_code_o <= `PS_WAIT;
         end
         else if (req_s2 != ack_tog)
         begin
            ack_tog <= req_s2;
            pipeline_state_code_o <= word_code;
            if (word_branch)
            begin
               // Four eight-bit packets, low nibble of each first
               nib_left <= `GROUP_NIBBLES - 4'h1;
               shift <= word_addr[31:4];
               packet_nibble_bus_o <= word_addr[3:0];
               packet_group_marker_o <= 1'b1;
            end
            else
            begin
               packet_nibble_bus_o <= 4'h0;
               packet_group_marker_o <= 1'b0;
            end
         end
         else
         begin
            pipeline_state_code_o <= `PS_WAIT;
            packet_group_marker_o <= 1'b0;
            packet_nibble_bus_o <= 4'h0;
         end
      end
   end

endmodule
`default_nettype wire

/* core/trace_consts.svh */
`ifndef TRACE_CONSTS_SVH
`define TRACE_CONSTS_SVH

// Register byte offsets on the bus
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_RANGE_LO 8'h08
`define OFS_RANGE_HI 8'h0c
`define OFS_MAP_CTRL 8'h10
`define OFS_COUNTER 8'h14
`define OFS_CONFIG 8'h18

// Control register fields
`define CTRL_EN_BIT 0
`define CTRL_HALF_BIT 1
`define CTRL_SEL_LSB 2
`define CTRL_SEL_W 3

// Reset values
`define CTRL_RESET 32'h0000_0000
`define RANGE_LO_RESET 32'h0000_0000
`define RANGE_HI_RESET 32'hffff_ffff
`define MAP_RESET 4'hf
`define COUNT_RESET 16'h0000

// Pipeline state codes
`define PS_EXEC 3'h0
`define PS_NOEXEC 3'h1
`define PS_WAIT 3'h2
`define PS_BRANCH 3'h3
`define PS_IDLE 3'h4

// Nibbles in one branch address group (four packets)
`define GROUP_NIBBLES 4'h8
`define FIRST_PKT_HIGH 4'h7

// Resource counts: pairs, data comps, decoders, counters, sequencer, ext in
`define CONFIG_WORD 32'h0002_1401

`endif

/* core/trace_pkg.sv */
package trace_pkg;
   typedef logic [2:0] pipe_code_t;
   typedef enum logic [2:0] {
      SEL_ALWAYS,
      SEL_RANGE,
      SEL_MAP,
      SEL_COUNT,
      SEL_EXT
   } trig_sel_e;
endpackage

/* testbench/instruction_trace_unit_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
`include "trace_consts.svh"
module instruction_trace_unit_monitor (
   input wire logic mclk_i, // System clock
   input wire logic rst_n_i, // Reset
   input wire logic wb_cyc_i, // Cycle
   input wire logic wb_stb_i, // Strobe
   input wire logic wb_ack_o, // Acknowledge
   input wire logic buffer_full_stall_o, // Stall
   input wire logic trace_clk_i, // Link clock
   input wire logic trace_port_clock_o, // Trace clock out
   input wire logic [2:0] pipeline_state_code_o, // State code
   input wire logic packet_group_marker_o, // Marker
   input wire logic [3:0] packet_nibble_bus_o // Nibble
);
   wire logic [2:0] cd = pipeline_state_code_o;
   wire logic mk = packet_group_marker_o;
   wire logic [3:0] nb = packet_nibble_bus_o;
   // First packet spans two slots of two link cycles
   sequence s_first_pkt;
      mk [*4] ##1 !mk;
   endsequence
   sequence s_group_head;
      cd == `PS_BRANCH ##2 cd == `PS_WAIT;
   endsequence
   chk_ack_once: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one pulse");
   chk_stall_ends: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      $rose(buffer_full_stall_o) |-> ##[1:100] !buffer_full_stall_o) else $error("stall stuck");
   chk_idle_reset: assert property (@(posedge trace_clk_i)
      (!rst_n_i) [*6] |-> cd == `PS_IDLE && !mk && nb == 4'h0 && !trace_port_clock_o) else $error("not idle");
   chk_marker_code: assert property (@(posedge trace_clk_i) disable iff (!rst_n_i)
      $rose(mk) |-> s_group_head) else $error("marker without branch code");
   chk_marker_span: assert property (@(posedge trace_clk_i) disable iff (!rst_n_i)
      $rose(mk) |-> s_first_pkt) else $error("marker length wrong");
   chk_slot_hold: assert property (@(posedge trace_clk_i) disable iff (!rst_n_i)
      $changed(nb) || $changed(cd) |=> $stable(nb) && $stable(cd)) else $error("slot too short");
   chk_code_legal: assert property (@(posedge trace_clk_i) disable iff (!rst_n_i)
      cd <= `PS_IDLE) else $error("bad state code");
   chk_idle_quiet: assert property (@(posedge trace_clk_i) disable iff (!rst_n_i)
      (cd == `PS_IDLE) [*4] |-> !trace_port_clock_o && !mk && nb == 4'h0) else $error("idle not quiet");
endmodule
bind instruction_trace_unit instruction_trace_unit_monitor i_instruction_trace_unit_monitor (.mclk_i, .rst_n_i,
   .wb_cyc_i, .wb_stb_i, .wb_ack_o, .buffer_full_stall_o, .trace_clk_i, .trace_port_clock_o,
   .pipeline_state_code_o, .packet_group_marker_o, .packet_nibble_bus_o);
`default_nettype wire

/* testbench/trace_analyzer_model.sv */
`timescale 1ns/10ps
`default_nettype none
`include "trace_consts.svh"
module trace_analyzer_model (
   input wire logic port_clk_i, // Captured trace clock
   input wire logic half_i, // Sample on both edges
   input wire logic [2:0] code_i, // State code
   input wire logic marker_i, // First packet flag
   input wire logic [3:0] nibble_i, // Packet nibble
   output logic [31:0] addr_o, // Last branch target
   output logic [7:0] groups_o, // Groups taken
   output logic [7:0] bad_o, // Framing faults
   output logic [2:0] last_o // Last code other than wait or idle
);
   logic [31:0] word = 32'h0;
   int idx = 8;
   initial
   begin
      addr_o = 32'h0;
      groups_o = 8'h0;
      bad_o = 8'h0;
      last_o = `PS_IDLE;
   end
   // Half rate puts a slot on each clock edge
   always @(port_clk_i)
   begin
      if (half_i || port_clk_i)
      begin
         if (code_i != `PS_WAIT && code_i != `PS_IDLE)
            last_o = code_i;
         if (marker_i && code_i == `PS_BRANCH)
            idx = 0;
         else if (marker_i != (idx == 1))
            bad_o = bad_o + 8'h1;
         if (idx < 8)
         begin
            word[idx*4 +: 4] = nibble_i;
            idx = idx + 1;
            if (idx == 8)
            begin
               addr_o = word;
               groups_o = groups_o + 8'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* testbench/test_instruction_trace_unit.sv */
`timescale 1ns/10ps
`default_nettype none
`include "trace_consts.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
   $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module test_instruction_trace_unit
   import trace_pkg::*;
;
   logic mclk_i = 1'b0, trace_clk_i = 1'b0, rst_n_i = 1'b0, wb_cyc_i = 1'b0, wb_we_i = 1'b0;
   logic core_valid_i = 1'b0, core_branch_i = 1'b0, external_trigger_input_i = 1'b0, half = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0, core_target_i = 32'h0, wb_dat_o, got;
   logic wb_ack_o, buffer_full_stall_o, trace_port_clock_o, packet_group_marker_o;
   logic [2:0] pipeline_state_code_o;
   logic [2:0] last;
   logic core_cond_pass_i = 1'b1;
   logic [3:0] packet_nibble_bus_o;
   logic [7:0] groups, bad;
   int error_cnt = 0, n_tests = 0, cycles = 0;

   instruction_trace_unit i_instruction_trace_unit (.mclk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i(wb_cyc_i),
      .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .core_valid_i,
      .core_cond_pass_i, .core_branch_i, .core_pc_i(32'h0000_2000), .core_target_i,
      .buffer_full_stall_o, .external_trigger_input_i, .trace_clk_i, .trace_port_clock_o,
      .pipeline_state_code_o, .packet_group_marker_o, .packet_nibble_bus_o);
   trace_analyzer_model i_trace_analyzer_model (.port_clk_i(trace_port_clock_o), .half_i(half),
      .code_i(pipeline_state_code_o), .marker_i(packet_group_marker_o), .nibble_i(packet_nibble_bus_o),
      .addr_o(got), .groups_o(groups), .bad_o(bad), .last_o(last));

   always #50 mclk_i = ~mclk_i;
   initial
   begin
      #7;
      forever #15 trace_clk_i = ~trace_clk_i;
   end

   task automatic final_report();
      if (error_cnt == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge mclk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         error_cnt++;
         final_report();
      end
   end

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      wb_cyc_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      @(posedge mclk_i);
   endtask

   // Core holds its request until the stall shows it was taken
   task automatic issue(input logic br, input logic [31:0] t, input logic [7:0] g);
      int n;
      n = 0;
      core_branch_i <= br;
      core_target_i <= t;
      core_valid_i <= 1'b1;
      do @(posedge mclk_i); while (buffer_full_stall_o !== 1'b1 && ++n < 20);
      core_valid_i <= 1'b0;
      n = 0;
      while ((buffer_full_stall_o !== 1'b0 || groups !== g) && n++ < 60) @(posedge mclk_i);
   endtask

   task automatic t_regs();
      logic [31:0] q;
      bus(1'b1, `OFS_CONFIG, 32'h0, q);
      bus(1'b0, `OFS_CONFIG, 32'h0, q);
      `CHK("config", `CONFIG_WORD, q)
      bus(1'b0, `OFS_RANGE_HI, 32'h0, q);
      `CHK("range hi", `RANGE_HI_RESET, q)
      bus(1'b1, `OFS_RANGE_LO, 32'h0000_1000, q);
      bus(1'b0, `OFS_RANGE_LO, 32'h0, q);
      `CHK("range lo", 32'h0000_1000, q)
      bus(1'b0, 8'h40, 32'h0, q);
      `CHK("unmapped", 32'h0, q)
   endtask

   // Every trigger source is made true, so each select must trace
   task automatic t_select();
      logic [31:0] q;
      external_trigger_input_i <= 1'b1;
      for (int s = 0; s <= SEL_EXT; s++)
      begin
         bus(1'b1, `OFS_CTRL, 32'(s << `CTRL_SEL_LSB) | 32'h1, q);
         issue(1'b1, 32'h8000_0013 + 32'(s) * 32'h0110_1111, 8'(s + 1));
         `CHK("target", 32'h8000_0013 + 32'(s) * 32'h0110_1111, got)
         `CHK("branch code", `PS_BRANCH, last)
      end
      `CHK("framing", 8'h0, bad)
      issue(1'b0, 32'h0, 8'd5);
      `CHK("plain op", 8'd5, groups)
      `CHK("plain code", `PS_EXEC, last)
      core_cond_pass_i <= 1'b0;
      issue(1'b1, 32'h0, 8'd5);
      `CHK("skipped code", `PS_NOEXEC, last)
      `CHK("skipped branch", 8'd5, groups)
      core_cond_pass_i <= 1'b1;
   endtask

   // Counter holds tracing off until it has counted down; a cleared map bit blocks it
   task automatic t_count();
      logic [31:0] q;
      bus(1'b1, `OFS_COUNTER, 32'h0000_0003, q);
      bus(1'b0, `OFS_COUNTER, 32'h0, q);
      `CHK("counter load", 32'h3, q)
      bus(1'b1, `OFS_CTRL, 32'hd, q);
      issue(1'b1, 32'h5a5a_0f0f, 8'd7);
      `CHK("count target", 32'h5a5a_0f0f, got)
      bus(1'b0, `OFS_COUNTER, 32'h0, q);
      `CHK("counter end", 32'h0, q)
      bus(1'b0, `OFS_STATUS, 32'h0, q);
      `CHK("status", 32'h1d, q)
      bus(1'b1, `OFS_MAP_CTRL, 32'he, q);
      bus(1'b1, `OFS_CTRL, 32'h9, q);
      issue(1'b1, 32'h1234_5678, 8'd8);
      `CHK("map gated", 8'd7, groups)
   endtask

   task automatic t_ext();
      logic [31:0] q;
      external_trigger_input_i <= 1'b0;
      bus(1'b1, `OFS_CTRL, 32'h11, q);
      issue(1'b1, 32'h0bad_0000, 8'd6);
      `CHK("gated", 8'd5, groups)
      external_trigger_input_i <= 1'b1;
      issue(1'b1, 32'h0f0f_1234, 8'd6);
      `CHK("ext target", 32'h0f0f_1234, got)
   endtask

   task automatic t_half();
      logic [31:0] q;
      int n;
      half <= 1'b1;
      bus(1'b1, `OFS_CTRL, 32'h3, q);
      issue(1'b1, 32'hc0de_5a5a, 8'd8);
      `CHK("half target", 32'hc0de_5a5a, got)
      `CHK("half framing", 8'h0, bad)
      bus(1'b1, `OFS_CTRL, 32'h0, q);
      n = 0;
      while (pipeline_state_code_o !== `PS_IDLE && n++ < 20) @(posedge mclk_i);
      @(posedge mclk_i);
      `CHK("off code", `PS_IDLE, pipeline_state_code_o)
      `CHK("off clock", 1'b0, trace_port_clock_o)
   endtask

   initial
   begin
      repeat (16) @(posedge mclk_i);
      `CHK("reset code", `PS_IDLE, pipeline_state_code_o)
      `CHK("reset marker", 1'b0, packet_group_marker_o)
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      t_regs();
      t_select();
      t_ext();
      t_count();
      t_half();
      final_report();
   end
endmodule
`default_nettype wire
